// File: inc/occ_params.svh
// register map, field positions, reset values and mode codes of the compare channel
// assumes a 16-bit register port with word indices on a 3-bit address
`ifndef OCC_PARAMS_SVH
`define OCC_PARAMS_SVH

`define OCC_ADDR_W 3
`define OCC_DATA_W 16

`define OCC_ADDR_CTRL 3'h0
`define OCC_ADDR_PRI 3'h1
`define OCC_ADDR_SEC 3'h2
`define OCC_ADDR_IRQ_STAT 3'h3
`define OCC_ADDR_IRQ_MASK 3'h4
`define OCC_ADDR_STATE 3'h5

`define OCC_CTRL_IDLE_BIT 13
`define OCC_CTRL_FLT_BIT 4
`define OCC_CTRL_TSEL_BIT 3
`define OCC_CTRL_MODE_LSB 0

`define OCC_IRQ_W 2
`define OCC_IRQ_EVT_BIT 0
`define OCC_IRQ_FLT_BIT 1

`define OCC_RST_MODE 3'h0
`define OCC_RST_CMP 16'h0000
`define OCC_RST_IRQ 2'h0

`define OCC_MODE_OFF 3'h0
`define OCC_MODE_SET_HI 3'h1
`define OCC_MODE_SET_LO 3'h2
`define OCC_MODE_TOGGLE 3'h3
`define OCC_MODE_ONE_PULSE 3'h4
`define OCC_MODE_CONT_PULSE 3'h5
`define OCC_MODE_PWM 3'h6
`define OCC_MODE_PWM_FLT 3'h7

`define OCC_SYNC_STAGES 3

`endif

// File: inc/occ_pkg.sv
// types shared by the compare channel modules
// assumes occ_params.svh on the include path
`include "occ_params.svh"

package occ_pkg;

    typedef enum logic [2:0] {
        OCC_M_OFF = `OCC_MODE_OFF,
        OCC_M_SET_HI = `OCC_MODE_SET_HI,
        OCC_M_SET_LO = `OCC_MODE_SET_LO,
        OCC_M_TOGGLE = `OCC_MODE_TOGGLE,
        OCC_M_ONE_PULSE = `OCC_MODE_ONE_PULSE,
        OCC_M_CONT_PULSE = `OCC_MODE_CONT_PULSE,
        OCC_M_PWM = `OCC_MODE_PWM,
        OCC_M_PWM_FLT = `OCC_MODE_PWM_FLT
    } occ_mode_t;

    typedef enum logic [1:0] {
        OCC_ST_IDLE,
        OCC_ST_WAIT_RISE,
        OCC_ST_WAIT_FALL,
        OCC_ST_DONE
    } occ_pulse_st_t;

endpackage

// File: inc/occ_tb_if.sv
// link between the channel core and its time base selector
// assumes both ends run on the same clock
`timescale 1ns/100ps

interface occ_tb_if #(
    parameter int CNT_W = 16
);
    logic tsel;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_b;
    logic match_a;
    logic match_b;
    logic rollover;

    modport core (output tsel, output cmp_a, output cmp_b, input match_a, input match_b, input rollover);
    modport tbase (input tsel, input cmp_a, input cmp_b, output match_a, output match_b, output rollover);
endinterface

// File: rtl/occ_timebase.sv
// time base selection and compare match detection
// assumes timer counts and period ticks come from logic on clk
`timescale 1ns/100ps

module occ_timebase #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [CNT_W-1:0] timer_a_count,
    input wire logic [CNT_W-1:0] timer_b_count,
    input wire logic timer_a_period_tick,
    input wire logic timer_b_period_tick,
    occ_tb_if.tbase tb
);
    logic [CNT_W-1:0] count;
    logic eq_a;
    logic eq_b;
    logic eq_a_q;
    logic eq_b_q;

    assign count = tb.tsel ? timer_b_count : timer_a_count; // RULE_11
    assign eq_a = (count == tb.cmp_a);
    assign eq_b = (count == tb.cmp_b);

    // a prescaled timer holds a value many cycles, so only the first cycle counts
    assign tb.match_a = eq_a && !eq_a_q;
    assign tb.match_b = eq_b && !eq_b_q;
    assign tb.rollover = tb.tsel ? timer_b_period_tick : timer_a_period_tick; // RULE_11

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            eq_a_q <= 1'b0;
            eq_b_q <= 1'b0;
        end else begin
            eq_a_q <= eq_a;
            eq_b_q <= eq_b;
        end
    end
endmodule

// File: rtl/occ_top.sv
// one output compare channel: control register, compare modes, pwm with fault, interrupt
// assumes timers and cpu idle come from logic on clk; the fault pin is asynchronous
//
// Summary of operation
// RULE_01 - mode 000 disables all compare activity
// RULE_02 - mode 011 toggles pin on each match
// RULE_03 - mode 100 starts low, one pulse
// RULE_04 - mode 101 starts low, repeated pulses
// RULE_05 - mode 110 is pwm, fault ignored
// RULE_06 - mode 111 is pwm, fault forces output
// RULE_07 - fault flag bit 4, read-only, hardware cleared
// RULE_08 - idle bit 13 halts channel in idle
// RULE_09 - mode 010 starts high, match drives low
// RULE_10 - mode 001 starts low, match drives high
// RULE_11 - timer select picks one of two timers
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

module occ_top
    import occ_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`OCC_ADDR_W-1:0] reg_addr,
    input wire logic [`OCC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`OCC_DATA_W-1:0] reg_rdata,
    input wire logic [CNT_W-1:0] timer_a_count,
    input wire logic [CNT_W-1:0] timer_b_count,
    input wire logic timer_a_period_tick,
    input wire logic timer_b_period_tick,
    input wire logic cpu_idle,
    input wire logic fault_pin_b,
    output logic compare_output_pin,
    output logic compare_output_en,
    output logic irq
);
    occ_tb_if #(.CNT_W(CNT_W)) tbl ();

    occ_timebase #(.CNT_W(CNT_W)) u_tbase (
        .clk(clk),
        .rst_b(rst_b),
        .timer_a_count(timer_a_count),
        .timer_b_count(timer_b_count),
        .timer_a_period_tick(timer_a_period_tick),
        .timer_b_period_tick(timer_b_period_tick),
        .tb(tbl.tbase)
    );

    // control and compare registers
    logic idle_halt_select_q;
    logic timer_source_select_q;
    occ_mode_t compare_mode_field_q;
    logic fault_status_flag_q;
    logic fault_status_flag_d;
    logic [CNT_W-1:0] pri_cmp_q;
    logic [CNT_W-1:0] sec_cmp_q;
    logic [CNT_W-1:0] duty_q;
    logic [`OCC_IRQ_W-1:0] irq_stat_q;
    logic [`OCC_IRQ_W-1:0] irq_stat_d;
    logic [`OCC_IRQ_W-1:0] irq_mask_q;
    logic [`OCC_DATA_W-1:0] reg_rdata_q;
    logic [`OCC_DATA_W-1:0] rdata_d;

    // fault pin synchroniser
    logic [`OCC_SYNC_STAGES-1:0] flt_sync_q;
    logic fault_level_b_q;

    // output generation
    logic pin_q;
    logic pin_d;
    occ_pulse_st_t pulse_st_q;
    occ_pulse_st_t pulse_st_d;

    function automatic logic hit(input logic [`OCC_ADDR_W-1:0] a, input logic [`OCC_ADDR_W-1:0] target);
        hit = (a == target);
    endfunction

    // bus decode
    logic wr_ctrl;
    logic wr_pri;
    logic wr_sec;
    logic wr_stat;
    logic wr_mask;
    occ_mode_t wr_mode;
    logic mode_change;
    assign wr_ctrl = reg_wr && hit(reg_addr, `OCC_ADDR_CTRL);
    assign wr_pri = reg_wr && hit(reg_addr, `OCC_ADDR_PRI);
    assign wr_sec = reg_wr && hit(reg_addr, `OCC_ADDR_SEC);
    assign wr_stat = reg_wr && hit(reg_addr, `OCC_ADDR_IRQ_STAT);
    assign wr_mask = reg_wr && hit(reg_addr, `OCC_ADDR_IRQ_MASK);
    assign wr_mode = occ_mode_t'(reg_wdata[`OCC_CTRL_MODE_LSB +: 3]);
    // reinit only on a real mode change, so touching other control bits keeps the pin
    assign mode_change = wr_ctrl && (wr_mode != compare_mode_field_q);

    // channel activity
    logic running;
    logic is_pwm;
    logic fault_now;
    logic ev_a;
    logic ev_b;
    logic ev_roll;
    assign running = !(idle_halt_select_q && cpu_idle); // RULE_08
    assign is_pwm = (compare_mode_field_q == OCC_M_PWM) || (compare_mode_field_q == OCC_M_PWM_FLT);
    // a halted channel ignores the fault pin as well, so the pin really holds in idle
    assign fault_now = running && (compare_mode_field_q == OCC_M_PWM_FLT) && !fault_level_b_q; // RULE_06 RULE_05
    assign ev_a = running && tbl.match_a;
    assign ev_b = running && tbl.match_b;
    assign ev_roll = running && tbl.rollover;

    assign tbl.tsel = timer_source_select_q; // RULE_11
    // pwm compares against the latched duty, other modes against the primary value
    assign tbl.cmp_a = is_pwm ? duty_q : pri_cmp_q;
    assign tbl.cmp_b = sec_cmp_q;

    // output pin next value
    always_comb begin
        pin_d = pin_q;
        pulse_st_d = pulse_st_q;
        if (mode_change) begin
            case (wr_mode)
                OCC_M_SET_LO: pin_d = 1'b1; // RULE_09
                OCC_M_SET_HI: pin_d = 1'b0; // RULE_10
                OCC_M_ONE_PULSE, OCC_M_CONT_PULSE: begin
                    pin_d = 1'b0; // RULE_03 RULE_04
                    pulse_st_d = OCC_ST_WAIT_RISE;
                end
                default: pin_d = 1'b0;
            endcase
            if (wr_mode != OCC_M_ONE_PULSE && wr_mode != OCC_M_CONT_PULSE) begin
                pulse_st_d = OCC_ST_IDLE;
            end
        end else begin
            case (compare_mode_field_q)
                OCC_M_OFF: pin_d = 1'b0; // RULE_01
                OCC_M_SET_HI: begin
                    if (ev_a) begin
                        pin_d = 1'b1; // RULE_10
                    end
                end
                OCC_M_SET_LO: begin
                    if (ev_a) begin
                        pin_d = 1'b0; // RULE_09
                    end
                end
                OCC_M_TOGGLE: begin
                    if (ev_a) begin
                        pin_d = !pin_q; // RULE_02
                    end
                end
                OCC_M_ONE_PULSE, OCC_M_CONT_PULSE: begin
                    case (pulse_st_q)
                        OCC_ST_WAIT_RISE: begin
                            if (ev_a) begin
                                pin_d = 1'b1;
                                pulse_st_d = OCC_ST_WAIT_FALL;
                            end
                        end
                        OCC_ST_WAIT_FALL: begin
                            if (ev_b) begin
                                pin_d = 1'b0;
                                // single mode stops after one pulse
                                pulse_st_d = (compare_mode_field_q == OCC_M_CONT_PULSE) ?
                                    OCC_ST_WAIT_RISE : OCC_ST_DONE; // RULE_03 RULE_04
                            end
                        end
                        OCC_ST_DONE: pin_d = 1'b0; // RULE_03
                        default: pulse_st_d = OCC_ST_WAIT_RISE;
                    endcase
                end
                OCC_M_PWM, OCC_M_PWM_FLT: begin
                    if (fault_now || fault_status_flag_q) begin
                        pin_d = 1'b0; // RULE_06
                    end else if (ev_roll) begin
                        pin_d = (sec_cmp_q != `OCC_RST_CMP); // RULE_05
                    end else if (ev_a) begin
                        pin_d = 1'b0; // RULE_05
                    end
                end
                default: pin_d = 1'b0;
            endcase
        end
    end

    // fault flag: set on fault, cleared by hardware at a period end once the pin is quiet
    always_comb begin
        fault_status_flag_d = fault_status_flag_q;
        if (compare_mode_field_q != OCC_M_PWM_FLT || mode_change) begin
            fault_status_flag_d = 1'b0; // RULE_07
        end else if (fault_now) begin
            fault_status_flag_d = 1'b1; // RULE_07
        end else if (ev_roll) begin
            fault_status_flag_d = 1'b0; // RULE_07
        end
    end

    // sticky events; a new event wins over a write-one clear
    logic [`OCC_IRQ_W-1:0] irq_set;
    logic [`OCC_IRQ_W-1:0] irq_clr;
    logic chan_event;
    assign chan_event = is_pwm ? ev_roll : ((compare_mode_field_q != OCC_M_OFF) && (ev_a || ev_b));
    assign irq_set[`OCC_IRQ_EVT_BIT] = chan_event;
    assign irq_set[`OCC_IRQ_FLT_BIT] = fault_status_flag_d && !fault_status_flag_q;
    assign irq_clr = wr_stat ? reg_wdata[`OCC_IRQ_W-1:0] : `OCC_RST_IRQ;
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    assign irq = |(irq_stat_q & irq_mask_q);

    // read mux
    always_comb begin
        rdata_d = '0;
        case (reg_addr)
            `OCC_ADDR_CTRL: begin
                rdata_d[`OCC_CTRL_IDLE_BIT] = idle_halt_select_q;
                rdata_d[`OCC_CTRL_FLT_BIT] = fault_status_flag_q; // RULE_07
                rdata_d[`OCC_CTRL_TSEL_BIT] = timer_source_select_q;
                rdata_d[`OCC_CTRL_MODE_LSB +: 3] = compare_mode_field_q;
            end
            `OCC_ADDR_PRI: rdata_d[CNT_W-1:0] = pri_cmp_q;
            `OCC_ADDR_SEC: rdata_d[CNT_W-1:0] = sec_cmp_q;
            `OCC_ADDR_IRQ_STAT: rdata_d[`OCC_IRQ_W-1:0] = irq_stat_q;
            `OCC_ADDR_IRQ_MASK: rdata_d[`OCC_IRQ_W-1:0] = irq_mask_q;
            `OCC_ADDR_STATE: rdata_d[3:0] = {!fault_level_b_q, running, pulse_st_q == OCC_ST_DONE, pin_q};
            default: rdata_d = '0;
        endcase
    end

    assign reg_rdata = reg_rdata_q;
    assign compare_output_pin = pin_q;
    assign compare_output_en = (compare_mode_field_q != OCC_M_OFF); // RULE_01

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idle_halt_select_q <= 1'b0;
            timer_source_select_q <= 1'b0;
            compare_mode_field_q <= OCC_M_OFF;
        end else if (wr_ctrl) begin
            idle_halt_select_q <= reg_wdata[`OCC_CTRL_IDLE_BIT]; // RULE_08
            timer_source_select_q <= reg_wdata[`OCC_CTRL_TSEL_BIT]; // RULE_11
            compare_mode_field_q <= wr_mode;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pri_cmp_q <= `OCC_RST_CMP;
            sec_cmp_q <= `OCC_RST_CMP;
        end else begin
            if (wr_pri) begin
                pri_cmp_q <= reg_wdata[CNT_W-1:0];
            end
            if (wr_sec) begin
                sec_cmp_q <= reg_wdata[CNT_W-1:0];
            end
        end
    end

    // duty taken only at a period end or on a mode change, so a mid-period write to the secondary value cannot glitch the pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            duty_q <= `OCC_RST_CMP;
        end else if (mode_change || (ev_roll && is_pwm)) begin
            duty_q <= sec_cmp_q; // RULE_05
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q <= 1'b0;
            pulse_st_q <= OCC_ST_IDLE;
            fault_status_flag_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            pulse_st_q <= pulse_st_d;
            fault_status_flag_q <= fault_status_flag_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_q <= `OCC_RST_IRQ;
            irq_mask_q <= `OCC_RST_IRQ;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_mask) begin
                irq_mask_q <= reg_wdata[`OCC_IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q <= '0;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end else begin
            reg_rdata_q <= '0;
        end
    end

    // pin idles high (no fault); level accepted only when stages two and three agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flt_sync_q <= '1;
            fault_level_b_q <= 1'b1;
        end else begin
            flt_sync_q <= {flt_sync_q[`OCC_SYNC_STAGES-2:0], fault_pin_b};
            if (flt_sync_q[1] == flt_sync_q[2]) begin
                fault_level_b_q <= flt_sync_q[2];
            end
        end
    end
endmodule

// File: test/occ_load.sv
// behavioural load on the compare output: counts driven pin edges, sources the fault line
// assumes the same clock as the channel
`timescale 1ns/100ps

module occ_load (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    input wire logic en,
    input wire logic fault_req,
    output logic fault_pin_b,
    output logic [15:0] edges
);
    logic last_q;

    // fault line active low, inactive unless the bench asks for a fault
    assign fault_pin_b = !fault_req;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q <= 1'b0;
            edges <= 16'h0;
        end else begin
            last_q <= pin;
            // an undriven pin is no load activity
            if (en && pin !== last_q) begin
                edges <= edges + 16'h1;
            end
        end
    end
endmodule

// File: test/occ_top_properties.sv
// port-level assertions for the compare channel
// assumes occ_params.svh on the include path; bound into every occ_top
`timescale 1ns/100ps
`include "occ_params.svh"

module occ_top_properties #(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [`OCC_ADDR_W-1:0] reg_addr,
    input wire logic [`OCC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`OCC_DATA_W-1:0] reg_rdata,
    input wire logic [CNT_W-1:0] timer_a_count,
    input wire logic [CNT_W-1:0] timer_b_count,
    input wire logic cpu_idle,
    input wire logic fault_pin_b,
    input wire logic compare_output_pin,
    input wire logic compare_output_en,
    input wire logic irq
);
    logic [2:0] mode_q;
    logic tsel_q;
    logic idle_q;
    logic eq_q;
    logic [CNT_W-1:0] pri_q;
    wire ctrl_wr = reg_wr && (reg_addr == `OCC_ADDR_CTRL);
    wire [CNT_W-1:0] sel_cnt = tsel_q ? timer_b_count : timer_a_count;
    wire eq = (sel_cnt == pri_q);
    wire halted = idle_q && cpu_idle;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= `OCC_RST_MODE;
            tsel_q <= 1'b0;
            idle_q <= 1'b0;
            eq_q <= 1'b0;
            pri_q <= `OCC_RST_CMP;
        end else begin
            eq_q <= eq;
            if (ctrl_wr) begin
                mode_q <= reg_wdata[2:0];
                tsel_q <= reg_wdata[`OCC_CTRL_TSEL_BIT];
                idle_q <= reg_wdata[`OCC_CTRL_IDLE_BIT];
            end
            if (reg_wr && reg_addr == `OCC_ADDR_PRI) begin
                pri_q <= reg_wdata[CNT_W-1:0];
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_en_follows_mode: assert property (compare_output_en == (mode_q != 3'h0))
        else $error("output enable disagrees with mode");
    a_off_pin_still: assert property (mode_q == 3'h0 && $past(mode_q) == 3'h0 |-> $stable(compare_output_pin))
        else $error("pin moved while channel off");
    a_toggle_on_match: assert property (mode_q == 3'h3 && eq && !eq_q && !halted
        && !reg_wr && !$past(reg_wr) |=> compare_output_pin != $past(compare_output_pin))
        else $error("match did not toggle the pin");
    a_idle_pin_hold: assert property (halted && mode_q != 3'h0 && !reg_wr |=> $stable(compare_output_pin))
        else $error("pin moved while halted in idle");
    a_init_low_start: assert property (ctrl_wr && reg_wdata[2:0] != mode_q
        && reg_wdata[2:0] inside {3'h1, 3'h4, 3'h5} |=> !compare_output_pin)
        else $error("pin not initialised low");
    a_init_high_start: assert property (ctrl_wr && reg_wdata[2:0] == 3'h2 && mode_q != 3'h2 |=> compare_output_pin)
        else $error("pin not initialised high");
    a_fault_forces_low: assert property ((mode_q == 3'h7 && !fault_pin_b) [*6] |-> !compare_output_pin)
        else $error("pin not forced low on fault");
    a_flag_quiet: assert property (reg_rd && reg_addr == `OCC_ADDR_CTRL && mode_q != 3'h7 |=> !reg_rdata[4])
        else $error("fault flag set outside faultable pwm");

    c_toggle: cover property (mode_q == 3'h3 && eq && !eq_q);
    c_fault: cover property ((mode_q == 3'h7 && !fault_pin_b) [*6]);
    c_irq: cover property ($rose(irq));
endmodule

bind occ_top occ_top_properties #(.CNT_W(CNT_W)) u_props (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_a_count(timer_a_count),
    .timer_b_count(timer_b_count), .cpu_idle(cpu_idle), .fault_pin_b(fault_pin_b),
    .compare_output_pin(compare_output_pin), .compare_output_en(compare_output_en), .irq(irq));

// File: test/occ_top_tb_top.sv
// self-checking bench: register port, every mode, idle halt, timer select, pwm fault, interrupt
// assumes occ_load as pin load and the bound port checker
`timescale 1ns/100ps
`include "occ_params.svh"

module occ_top_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] ta = 16'h0;
    logic [15:0] tb = 16'h0;
    logic tick_a = 1'b0;
    logic tick_b = 1'b0;
    logic cpu_idle = 1'b0;
    logic fault_req = 1'b0;
    logic fault_pin_b;
    logic pin;
    logic pin_en;
    logic irq;
    logic [15:0] edges;
    logic [15:0] e0;
    logic rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [31:0] rnd;
    int n;
    int fails = 0;
    int tests_run = 0;
    int seed = 32'h567f0595;
    // one row per mode setup: control word, idle, fault, edges in 128 cycles, final pin
    logic [15:0] r_ctrl [12] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h000b, 16'h2003, 16'h0003,
        16'h0004, 16'h0005, 16'h0006, 16'h000e, 16'h0007};
    logic [15:0] r_edges [12] = '{16'h0, 16'h1, 16'h1, 16'h4, 16'h2, 16'h0, 16'h4, 16'h2, 16'h8, 16'h8, 16'h4,
        16'h0};
    logic [11:0] r_idle = 12'b000001100000;
    logic [11:0] r_flt = 12'b111000000000;
    logic [11:0] r_pin = 12'b000000000010;

    occ_top #(.CNT_W(16)) uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_a_count(ta), .timer_b_count(tb),
        .timer_a_period_tick(tick_a), .timer_b_period_tick(tick_b), .cpu_idle(cpu_idle),
        .fault_pin_b(fault_pin_b), .compare_output_pin(pin), .compare_output_en(pin_en), .irq(irq));
    occ_load u_load (.clk(clk), .rst_b(rst_b), .pin(pin), .en(pin_en), .fault_req(fault_req),
        .fault_pin_b(fault_pin_b), .edges(edges));

    initial begin
        forever #5 clk = ~clk;
    end

    // timer a period 32, timer b period 64, so the selected base shows in the edge count
    always @(posedge clk) begin
        ta <= (ta == 16'h001f) ? 16'h0 : ta + 16'h1;
        tb <= (tb == 16'h003f) ? 16'h0 : tb + 16'h1;
        tick_a <= (ta == 16'h001e);
        tick_b <= (tb == 16'h003e);
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(exp);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) rd_seen <= reg_rd;

    // read data stand only in the cycle after the strobe
    always @(negedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                fails++;
            end else begin
                chk(reg_rdata, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk({14'h0, irq, pin_en}, 16'h0);
        rd(`OCC_ADDR_CTRL, 16'h0);
        rd(`OCC_ADDR_STATE, 16'h0004);
        rnd = $random(seed);
        wr(3'h7, rnd[15:0]);
        rd(3'h7, 16'h0);
        rd(3'h6, 16'h0);
        wr(`OCC_ADDR_PRI, 16'h0004);
        wr(`OCC_ADDR_SEC, 16'h000c);
        rd(`OCC_ADDR_SEC, 16'h000c);
        rd(`OCC_ADDR_PRI, 16'h0004);
        $display("test register port done");
        for (int i = 0; i < 12; i++) begin
            wr(`OCC_ADDR_CTRL, 16'h0);
            cpu_idle <= r_idle[i];
            fault_req <= r_flt[i];
            n = 0;
            // land the mode write between the second match and the period end
            while (ta != 16'h0012 && n < 64) begin
                @(posedge clk);
                n++;
            end
            if (n == 64) begin
                fails++;
                end_sim();
            end
            rnd = $random(seed);
            wr(`OCC_ADDR_CTRL, r_ctrl[i] | (rnd[15:0] & 16'hdff0));
            repeat (2) @(posedge clk);
            @(negedge clk);
            e0 = edges;
            repeat (128) @(posedge clk);
            @(negedge clk);
            chk(edges - e0, r_edges[i]);
            chk({15'h0, pin}, {15'h0, r_pin[i]});
            rd(`OCC_ADDR_CTRL, r_ctrl[i] | {11'h0, r_flt[i] && r_ctrl[i][2:0] == 3'h7, 4'h0});
            rd(`OCC_ADDR_STATE, {12'h0, r_flt[i], !(r_ctrl[i][13] && r_idle[i]), r_ctrl[i][2:0] == 3'h4, r_pin[i]});
            $display("test mode row %0d done", i);
        end
        fault_req <= 1'b0;
        cpu_idle <= 1'b0;
        repeat (80) @(posedge clk);
        rd(`OCC_ADDR_CTRL, 16'h0007);
        wr(`OCC_ADDR_CTRL, 16'h0);
        rd(`OCC_ADDR_IRQ_STAT, 16'h0003);
        wr(`OCC_ADDR_IRQ_STAT, 16'h0003);
        rd(`OCC_ADDR_IRQ_STAT, 16'h0);
        wr(`OCC_ADDR_CTRL, 16'h0003);
        repeat (40) @(posedge clk);
        rd(`OCC_ADDR_IRQ_STAT, 16'h0001);
        @(negedge clk);
        chk({15'h0, irq}, 16'h0);
        wr(`OCC_ADDR_IRQ_MASK, 16'h0001);
        @(negedge clk);
        chk({15'h0, irq}, 16'h1);
        rd(`OCC_ADDR_IRQ_MASK, 16'h0001);
        wr(`OCC_ADDR_CTRL, 16'h0);
        wr(`OCC_ADDR_IRQ_STAT, 16'h0001);
        @(negedge clk);
        chk({15'h0, irq}, 16'h0);
        $display("test interrupt done");
        repeat (4) @(posedge clk);
        end_sim();
    end
endmodule
